// ==== sccs_clk_if.sv ====
interface sccs_clk_if;
    logic prim_lvl;
    logic sec_lvl;
    logic slow_lvl;
    logic fast_lvl;
    logic fast_stable;
    logic post_lvl;
    modport sync_src(output prim_lvl, sec_lvl, slow_lvl, fast_lvl, fast_stable);
    modport post(input fast_lvl, slow_lvl, output post_lvl);
    modport core(input prim_lvl, sec_lvl, slow_lvl, fast_lvl, fast_stable, post_lvl);
endinterface

// ==== sccs_clock_select.sv ====
// Functional notes
// - device clock picks primary, secondary oscillator or postscaled internal clock.
// - select codes 11 internal, 01 secondary, 00 primary, 10 reserved.
// - after a select write, switch to the new source after a short transition.
// - switch runs two more old-source cycles, then holds clock low for three new-source cycles.
// - every reset clears the select field, returning to the primary source.
// - three-bit frequency field picks slow osc, fast osc or a postscaled rate.
// - 111 8M, 110 4M, 101 2M, 100 1M, 011 500k, 010 250k, 001 125k, 000 31k.
// - frequency field changes take effect at once on the internal clock.
// - reset sets the postscaler to the 4 MHz output.
// - at code 000, low-frequency bit picks fast osc divided by 256 or slow osc.
// - watchdog always runs from the slow oscillator.
// - startup-done set when timer expired and primary drives the clock.
// - secondary-active set while the secondary oscillator drives the clock.
// - at most one of startup-done and secondary-active is set.
// - idle-enable decides whether sleep request enters sleep or idle.
// - secondary select ignored unless oscillator enable or digital-input config set.
// - primary oscillator mode fixed by the three-bit mode configuration field.
// - secondary oscillator keeps running in power-managed modes.
// - full-speed USB needs the 48 MHz PLL clock; plain external clock is low-speed.
// - fast internal osc feeding the PLL may source the USB clock.
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
module sccs_clock_select import sccs_pkg::*; #(
    parameter int STARTUP_COUNT = STARTUP_EDGES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic primary_clk_pin,
    input wire logic secondary_clk_pin,
    input wire logic slow_internal_osc,
    input wire logic fast_internal_osc,
    input wire logic fast_osc_stable,
    input wire logic sleep_request,
    output logic device_clk,
    output logic watchdog_clk,
    output logic sleep_enter,
    output logic idle_enter,
    output logic secondary_osc_run,
    output logic pll_enable,
    output logic pll_ref_internal,
    output logic usb_full_speed_ok
);
    localparam int OSTW = $clog2(STARTUP_COUNT + 1);
    localparam logic [OSTW-1:0] OST_LAST = OSTW'(STARTUP_COUNT);

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic idle_en;
        logic [2:0] ifs;
        logic [1:0] sel;
        logic lfs;
        logic [2:0] mode;
        logic dig_cfg;
        logic sosc_en;
        logic [1:0] active;
        logic [1:0] target;
        sccs_sw_state_t sw;
        logic [1:0] edge_cnt;
        logic src_prev;
        logic prim_prev;
        logic [OSTW-1:0] ost_cnt;
        logic ost_done;
        logic dev_clk;
        logic wdt_clk;
        logic sleep_p;
        logic idle_p;
        logic sosc_run;
        logic pll_en;
        logic pll_int;
        logic usb_fs;
        logic ph_valid;
        logic ph_write;
        logic [11:0] ph_idx;
        logic ready_o;
        logic resp_o;
        logic [31:0] rdata;
    } sccs_core_t;

    localparam sccs_core_t CORE_RESET = '{
        idle_en: 1'b0, ifs: IFS_RESET, sel: SEL_RESET, lfs: 1'b0, mode: MODE_RESET,
        dig_cfg: 1'b0, sosc_en: 1'b0, active: SEL_PRIMARY, target: SEL_PRIMARY,
        sw: SW_RUN, edge_cnt: 2'h0, src_prev: 1'b0, prim_prev: 1'b0,
        ost_cnt: '0, ost_done: 1'b0, dev_clk: 1'b0, wdt_clk: 1'b0,
        sleep_p: 1'b0, idle_p: 1'b0, sosc_run: 1'b0, pll_en: 1'b0,
        pll_int: 1'b0, usb_fs: 1'b0, ph_valid: 1'b0, ph_write: 1'b0,
        ph_idx: 12'h000, ready_o: 1'b1, resp_o: 1'b0, rdata: 32'h0000_0000};

    sccs_core_t st_reg;
    sccs_core_t st_next;
    sccs_clk_if clk_lnk();

    // ==========================================================
    // pin sampling and postscaler
    // ==========================================================
    sccs_pin_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pins({fast_osc_stable, fast_internal_osc, slow_internal_osc,
               secondary_clk_pin, primary_clk_pin}),
        .lnk(clk_lnk.sync_src)
    );

    sccs_postscaler u_post (
        .hclk(hclk),
        .hresetn(hresetn),
        .internal_freq_select(st_reg.ifs),
        .low_freq_source_select(st_reg.lfs),
        .lnk(clk_lnk.post)
    );

    // internal modes take the postscaler output as the primary clock
    function automatic logic src_level(input logic [1:0] src, input logic [2:0] mode,
                                       input logic prim, input logic sec,
                                       input logic post);
        case (src)
            SEL_SECONDARY: src_level = sec;
            SEL_INTERNAL: src_level = post;
            default: begin
                if (mode == MODE_FAST_INTERNAL_OSC || mode == MODE_FAST_INTERNAL_OSC_PLL) begin
                    src_level = post;
                end else begin
                    src_level = prim;
                end
            end
        endcase
    endfunction

    // ==========================================================
    // next state
    // ==========================================================
    logic old_lvl;
    logic new_lvl;
    logic addr_take;
    logic prim_rise;
    logic startup_bit;
    logic sec_bit;

    always_comb begin
        st_next = st_reg;
        old_lvl = src_level(st_reg.active, st_reg.mode, clk_lnk.prim_lvl,
                            clk_lnk.sec_lvl, clk_lnk.post_lvl);
        new_lvl = src_level(st_reg.target, st_reg.mode, clk_lnk.prim_lvl,
                            clk_lnk.sec_lvl, clk_lnk.post_lvl);
        prim_rise = clk_lnk.prim_lvl & ~st_reg.prim_prev;
        addr_take = hsel & hready & htrans[1];

        // startup timer on primary pin edges
        st_next.prim_prev = clk_lnk.prim_lvl;
        if (!st_reg.ost_done && prim_rise) begin
            st_next.ost_cnt = st_reg.ost_cnt + OSTW'(1);
            if (st_reg.ost_cnt == OST_LAST - OSTW'(1)) begin
                st_next.ost_done = 1'b1;
            end
        end

        // glitch-free switch
        case (st_reg.sw)
            SW_RUN: begin
                st_next.dev_clk = old_lvl;
                if (sccs_target(st_reg.sel) != st_reg.active) begin
                    st_next.target = sccs_target(st_reg.sel);
                    st_next.sw = SW_DRAIN_OLD;
                    st_next.edge_cnt = 2'h0;
                    st_next.src_prev = old_lvl;
                end
            end
            SW_DRAIN_OLD: begin
                st_next.dev_clk = old_lvl;
                st_next.src_prev = old_lvl;
                if (st_reg.src_prev && !old_lvl) begin
                    st_next.edge_cnt = st_reg.edge_cnt + 2'h1;
                    if (st_reg.edge_cnt == OLD_EDGES - 2'h1) begin
                        st_next.dev_clk = 1'b0;
                        st_next.sw = SW_WAIT_NEW;
                        st_next.edge_cnt = 2'h0;
                        st_next.src_prev = new_lvl;
                    end
                end
            end
            SW_WAIT_NEW: begin
                st_next.dev_clk = 1'b0;
                st_next.src_prev = new_lvl;
                if (!st_reg.src_prev && new_lvl) begin
                    st_next.edge_cnt = st_reg.edge_cnt + 2'h1;
                    if (st_reg.edge_cnt == NEW_EDGES - 2'h1) begin
                        st_next.dev_clk = new_lvl;
                        st_next.active = st_reg.target;
                        st_next.sw = SW_RUN;
                    end
                end
            end
            default: st_next.sw = SW_RUN;
        endcase

        // fixed-function outputs
        st_next.wdt_clk = clk_lnk.slow_lvl;
        st_next.sleep_p = sleep_request & ~st_reg.idle_en;
        st_next.idle_p = sleep_request & st_reg.idle_en;
        st_next.sosc_run = st_reg.sosc_en | (st_reg.active == SEL_SECONDARY);
        st_next.pll_en = st_reg.mode[0];
        st_next.pll_int = (st_reg.mode == MODE_FAST_INTERNAL_OSC_PLL);
        st_next.usb_fs = st_reg.mode[0];

        // bus data phase: writes
        if (st_reg.ph_valid && st_reg.ph_write) begin
            case (st_reg.ph_idx)
                OSC_CONTROL_IDX: begin
                    st_next.idle_en = hwdata[CTL_IDLE_BIT];
                    st_next.ifs = hwdata[CTL_IFS_LSB +: 3];
                    if (hwdata[CTL_SEL_LSB +: 2] != SEL_SECONDARY
                        || st_reg.sosc_en || st_reg.dig_cfg) begin
                        st_next.sel = hwdata[CTL_SEL_LSB +: 2];
                    end
                end
                OSC_TUNING_IDX: st_next.lfs = hwdata[TUNE_LFS_BIT];
                CLK_CONFIG_IDX: begin
                    st_next.mode = hwdata[CFG_MODE_LSB +: 3];
                    st_next.dig_cfg = hwdata[CFG_DIG_BIT];
                    st_next.sosc_en = hwdata[CFG_SOSC_EN_BIT];
                end
                default: st_next.ph_idx = st_reg.ph_idx;
            endcase
        end

        // bus address phase
        st_next.ph_valid = addr_take;
        st_next.ph_write = addr_take & hwrite;
        st_next.ph_idx = (haddr[31:14] == 18'h0_0000) ? haddr[13:2] : 12'h000;
        st_next.ready_o = 1'b1;
        st_next.resp_o = 1'b0;

        // status seen by reads, exclusive by construction
        startup_bit = st_reg.ost_done && st_reg.active == SEL_PRIMARY
                      && st_reg.sw == SW_RUN && st_reg.mode != MODE_FAST_INTERNAL_OSC
                      && st_reg.mode != MODE_FAST_INTERNAL_OSC_PLL;
        sec_bit = st_reg.active == SEL_SECONDARY && st_reg.sw == SW_RUN;

        // read data taken from post-write values
        st_next.rdata = 32'h0000_0000;
        if (addr_take && !hwrite) begin
            case (st_next.ph_idx)
                OSC_CONTROL_IDX: begin
                    st_next.rdata[CTL_IDLE_BIT] = st_next.idle_en;
                    st_next.rdata[CTL_IFS_LSB +: 3] = st_next.ifs;
                    st_next.rdata[CTL_STARTUP_BIT] = startup_bit;
                    st_next.rdata[CTL_STABLE_BIT] = clk_lnk.fast_stable;
                    st_next.rdata[CTL_SEL_LSB +: 2] = st_next.sel;
                end
                OSC_CONTROL_TWO_IDX: st_next.rdata[TWO_SEC_ACTIVE_BIT] = sec_bit;
                OSC_TUNING_IDX: st_next.rdata[TUNE_LFS_BIT] = st_next.lfs;
                CLK_CONFIG_IDX: begin
                    st_next.rdata[CFG_MODE_LSB +: 3] = st_next.mode;
                    st_next.rdata[CFG_DIG_BIT] = st_next.dig_cfg;
                    st_next.rdata[CFG_SOSC_EN_BIT] = st_next.sosc_en;
                end
                CLK_STATUS_IDX: begin
                    st_next.rdata[STAT_ACTIVE_LSB +: 2] = st_reg.active;
                    st_next.rdata[STAT_BUSY_BIT] = (st_reg.sw != SW_RUN);
                end
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= CORE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hreadyout = st_reg.ready_o;
    assign hresp = st_reg.resp_o;
    assign hrdata = st_reg.rdata;
    assign device_clk = st_reg.dev_clk;
    assign watchdog_clk = st_reg.wdt_clk;
    assign sleep_enter = st_reg.sleep_p;
    assign idle_enter = st_reg.idle_p;
    assign secondary_osc_run = st_reg.sosc_run;
    assign pll_enable = st_reg.pll_en;
    assign pll_ref_internal = st_reg.pll_int;
    assign usb_full_speed_ok = st_reg.usb_fs;
endmodule

// ==== sccs_monitor.sv ====
module sccs_monitor import sccs_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic slow_internal_osc,
    input wire logic sleep_request,
    input wire logic watchdog_clk,
    input wire logic sleep_enter,
    input wire logic idle_enter,
    input wire logic secondary_osc_run,
    input wire logic pll_enable,
    input wire logic pll_ref_internal,
    input wire logic usb_full_speed_ok
);
    // ==========
    // bus shadow
    // ==========
    localparam logic [31:0] A_CTL = 32'(OSC_CONTROL_IDX) << 2;
    localparam logic [31:0] A_CFG = 32'(CLK_CONFIG_IDX) << 2;
    logic wr_q;
    logic rd_q;
    logic [31:0] a_q;
    logic idle_b;
    logic sec_en;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            a_q <= 32'h0000_0000;
            idle_b <= 1'b0;
            sec_en <= 1'b0;
        end else if (hready) begin
            wr_q <= hsel && htrans[1] && hwrite;
            rd_q <= hsel && htrans[1] && !hwrite;
            a_q <= haddr;
            if (wr_q && a_q == A_CTL) begin
                idle_b <= hwdata[CTL_IDLE_BIT];
            end
            if (wr_q && a_q == A_CFG) begin
                sec_en <= hwdata[CFG_SOSC_EN_BIT];
            end
        end
    end
    // ==========
    // properties
    // ==========
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    chk_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0000_0000)
        else $error("read data outside a read");
    chk_sleep_kind: assert property (
        sleep_request |=> idle_enter == $past(idle_b) && sleep_enter != $past(idle_b))
        else $error("wrong low power entry");
    chk_sleep_quiet: assert property (!sleep_request |=> !sleep_enter && !idle_enter)
        else $error("entry without request");
    chk_wdog_follow: assert property (
        $stable(slow_internal_osc) [*7] |-> watchdog_clk == slow_internal_osc)
        else $error("watchdog clock not following");
    chk_usb_pll: assert property (usb_full_speed_ok == pll_enable)
        else $error("full speed flag mismatch");
    chk_ref_pll: assert property (pll_ref_internal |-> pll_enable && usb_full_speed_ok)
        else $error("internal reference without pll");
    chk_secrun_en: assert property (sec_en |-> ##[0:2] secondary_osc_run)
        else $error("secondary run flag low");
    cover property (sleep_request ##1 idle_enter);
    cover property (rd_q);
    cover property ($rose(secondary_osc_run));
endmodule

// ==== sccs_osc_model.sv ====
module sccs_osc_model (
    input wire logic sec_run,
    output logic primary_clk_pin,
    output logic secondary_clk_pin,
    output logic slow_internal_osc,
    output logic fast_internal_osc,
    output logic fast_osc_stable
);
    timeunit 1ns;
    timeprecision 1ps;
    // periods 1006, 1214, 2018 and 402 ns, off the bus clock grid
    initial begin
        primary_clk_pin = 1'b0;
        secondary_clk_pin = 1'b0;
        slow_internal_osc = 1'b0;
        fast_internal_osc = 1'b0;
        fast_osc_stable = 1'b0;
        #2317 fast_osc_stable = 1'b1;
    end
    always #503 primary_clk_pin = !primary_clk_pin;
    // crystal stands still unless started
    always #607 secondary_clk_pin = sec_run ? !secondary_clk_pin : 1'b0;
    always #1009 slow_internal_osc = !slow_internal_osc;
    always #201 fast_internal_osc = !fast_internal_osc;
endmodule

// ==== sccs_pin_sync.sv ====
module sccs_pin_sync import sccs_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [SYNC_W-1:0] pins,
    sccs_clk_if.sync_src lnk
);
    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] lvl;
    } sccs_sync_t;

    sccs_sync_t st_reg;
    sccs_sync_t st_next;
    logic [SYNC_W-1:0] agree;

    always_comb begin
        st_next = st_reg;
        st_next.s1 = pins;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        agree = ~(st_reg.s2 ^ st_reg.s3);
        st_next.lvl = (agree & st_reg.s3) | (~agree & st_reg.lvl);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lnk.prim_lvl = st_reg.lvl[0];
    assign lnk.sec_lvl = st_reg.lvl[1];
    assign lnk.slow_lvl = st_reg.lvl[2];
    assign lnk.fast_lvl = st_reg.lvl[3];
    assign lnk.fast_stable = st_reg.lvl[4];
endmodule

// ==== sccs_pkg.sv ====
package sccs_pkg;

    // ==========================================================
    // register indices, byte address is four times the index
    // ==========================================================
    localparam logic [11:0] OSC_CONTROL_IDX = 12'h0FD3;
    localparam logic [11:0] OSC_CONTROL_TWO_IDX = 12'h0F87;
    localparam logic [11:0] OSC_TUNING_IDX = 12'h0F9B;
    localparam logic [11:0] CLK_CONFIG_IDX = 12'h0F00;
    localparam logic [11:0] CLK_STATUS_IDX = 12'h0F01;

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int CTL_IDLE_BIT = 7;
    localparam int CTL_IFS_LSB = 4;
    localparam int CTL_STARTUP_BIT = 3;
    localparam int CTL_STABLE_BIT = 2;
    localparam int CTL_SEL_LSB = 0;
    localparam int TWO_SEC_ACTIVE_BIT = 6;
    localparam int TUNE_LFS_BIT = 7;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_DIG_BIT = 3;
    localparam int CFG_SOSC_EN_BIT = 4;
    localparam int STAT_ACTIVE_LSB = 0;
    localparam int STAT_BUSY_BIT = 2;

    // ==========================================================
    // encodings and reset values
    // ==========================================================
    localparam logic [1:0] SEL_PRIMARY = 2'h0;
    localparam logic [1:0] SEL_SECONDARY = 2'h1;
    localparam logic [1:0] SEL_RESERVED = 2'h2;
    localparam logic [1:0] SEL_INTERNAL = 2'h3;
    localparam logic [2:0] IFS_FAST_DIRECT = 3'h7;
    localparam logic [2:0] IFS_LOW = 3'h0;
    localparam logic [2:0] MODE_FAST_INTERNAL_OSC = 3'h0;
    localparam logic [2:0] MODE_FAST_INTERNAL_OSC_PLL = 3'h1;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic [2:0] IFS_RESET = 3'h6;
    localparam logic [2:0] MODE_RESET = 3'h4;

    // ==========================================================
    // timing counts in source clock edges, low divider bit and sync width
    // ==========================================================
    localparam logic [1:0] OLD_EDGES = 2'h2;
    localparam logic [1:0] NEW_EDGES = 2'h3;
    localparam int STARTUP_EDGES = 1024;
    localparam int LOW_DIV_BIT = 7;
    localparam int SYNC_W = 5;

    typedef enum logic [1:0] {SW_RUN, SW_DRAIN_OLD, SW_WAIT_NEW} sccs_sw_state_t;

    // reserved code falls back to the primary source
    function automatic logic [1:0] sccs_target(input logic [1:0] sel);
        sccs_target = (sel == SEL_RESERVED) ? SEL_PRIMARY : sel;
    endfunction

endpackage

// ==== sccs_postscaler.sv ====
module sccs_postscaler import sccs_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [2:0] internal_freq_select,
    input wire logic low_freq_source_select,
    sccs_clk_if.post lnk
);
    typedef struct packed {
        logic fast_prev;
        logic [7:0] cnt;
        logic lvl;
    } sccs_post_t;

    sccs_post_t st_reg;
    sccs_post_t st_next;
    logic rise;

    always_comb begin
        st_next = st_reg;
        rise = lnk.fast_lvl & ~st_reg.fast_prev;
        st_next.fast_prev = lnk.fast_lvl;
        st_next.cnt = st_reg.cnt + {7'h00, rise};
        // divide by two per step below the direct code down to 001; 000 divides by 256 or passes the slow osc
        case (internal_freq_select)
            IFS_FAST_DIRECT: st_next.lvl = lnk.fast_lvl;
            IFS_LOW: begin
                if (low_freq_source_select) begin
                    st_next.lvl = st_reg.cnt[LOW_DIV_BIT];
                end else begin
                    st_next.lvl = lnk.slow_lvl;
                end
            end
            default: st_next.lvl = st_reg.cnt[3'(3'h6 - internal_freq_select)];
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lnk.post_lvl = st_reg.lvl;
endmodule

// ==== system_clock_source_select_bench.sv ====
module system_clock_source_select_bench import sccs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A_CTL = 32'(OSC_CONTROL_IDX) << 2;
    localparam logic [31:0] A_TWO = 32'(OSC_CONTROL_TWO_IDX) << 2;
    localparam logic [31:0] A_TUN = 32'(OSC_TUNING_IDX) << 2;
    localparam logic [31:0] A_CFG = 32'(CLK_CONFIG_IDX) << 2;
    localparam logic [31:0] A_STA = 32'(CLK_STATUS_IDX) << 2;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic sleep_request = 1'b0;
    logic sec_run = 1'b0;
    logic hreadyout, hresp, device_clk, watchdog_clk, sleep_enter, idle_enter;
    logic secondary_osc_run, pll_enable, pll_ref_internal, usb_full_speed_ok;
    logic primary_clk_pin, secondary_clk_pin, slow_internal_osc;
    logic fast_internal_osc, fast_osc_stable;
    logic [31:0] hrdata;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #20 hclk = !hclk;
    sccs_clock_select #(.STARTUP_COUNT(8)) u_sccs_clock_select (.*, .hready(hreadyout));
    sccs_osc_model u_sccs_osc_model (.*);
    // ==========
    // reporting
    // ==========
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic near(input int got, input int exp);
        check(32'((got >= exp - 1) && (got <= exp + 1)), 32'h1);
    endtask
    // ==========
    // bus and measurement tasks
    // ==========
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        xfer(a, 1'b0, 32'h0000_0000, q);
    endtask
    task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                        output logic [31:0] q);
        for (int i = 0; i < 200; i++) begin
            rd(a, q);
            if ((q & m) === e) break;
        end
    endtask
    // clock rises over 400 cycles
    task automatic count(output int r, output int w);
        logic pd;
        logic pw;
        r = 0;
        w = 0;
        @(negedge hclk);
        pd = device_clk;
        pw = watchdog_clk;
        repeat (400) begin
            @(negedge hclk);
            r += int'(device_clk && !pd);
            w += int'(watchdog_clk && !pw);
            pd = device_clk;
            pw = watchdog_clk;
        end
    endtask
    // ==========
    // scenarios
    // ==========
    task automatic t_reset();
        logic [31:0] d;
        wr(32'h0000_0100, 32'hFFFF_FFFF);
        rd(32'h0000_0100, d);
        check(d, 32'h0);
        rd(A_CTL, d);
        check(d & 8'hF3, 8'h60);
        rd(A_STA, d);
        check(d & 8'h03, 8'h00);
        rd(A_CFG, d);
        check(d, 8'h04);
        rd(A_TUN, d);
        check(d, 8'h00);
    endtask
    task automatic t_startup();
        logic [31:0] d;
        int r;
        int w;
        poll(A_CTL, 8'h08, 8'h08, d);
        check(d & 8'h08, 8'h08);
        rd(A_TWO, d);
        check(d & 8'h40, 8'h00);
        count(r, w);
        near(r, 16);
        near(w, 8);
    endtask
    task automatic t_switch();
        logic [3:0] fl[5] = '{4'h7, 4'h6, 4'h5, 4'h8, 4'h0};
        int ex[5] = '{40, 20, 10, 0, 8};
        logic [31:0] d;
        int r;
        int w;
        wr(A_CTL, 8'h73);
        rd(A_STA, d);
        check(d & 8'h04, 8'h04);
        poll(A_STA, 8'h07, 8'h03, d);
        check(d & 8'h07, 8'h03);
        for (int i = 0; i < 5; i++) begin
            wr(A_TUN, {24'h0, fl[i][3], 7'h0});
            wr(A_CTL, {25'h0, fl[i][2:0], 4'h3});
            count(r, w);
            near(r, ex[i]);
            near(w, 8);
        end
        wr(A_CTL, 8'h62);
        poll(A_STA, 8'h07, 8'h00, d);
        check(d & 8'h07, 8'h00);
        count(r, w);
        near(r, 16);
    endtask
    task automatic t_secondary();
        logic [7:0] cf[3] = '{8'h04, 8'h14, 8'h0C};
        logic [31:0] d;
        int r;
        int w;
        for (int i = 0; i < 3; i++) begin
            @(posedge hclk);
            sec_run <= cf[i][4] | cf[i][3];
            wr(A_CFG, cf[i]);
            wr(A_CTL, 8'h61);
            rd(A_CTL, d);
            check(d & 8'h03, i > 0 ? 32'h1 : 32'h2);
            if (i > 0) begin
                poll(A_STA, 8'h07, 8'h01, d);
                check(d & 8'h07, 8'h01);
                rd(A_TWO, d);
                check(d & 8'h40, 8'h40);
                rd(A_CTL, d);
                check(d & 8'h08, 8'h00);
                check(secondary_osc_run, 1'b1);
                count(r, w);
                near(r, 13);
                wr(A_CTL, 8'h60);
                poll(A_STA, 8'h07, 8'h00, d);
            end
        end
        wr(A_CFG, 8'h04);
    endtask
    task automatic t_sleep();
        for (int i = 0; i < 2; i++) begin
            wr(A_CTL, {24'h0, i[0], 7'h60});
            @(posedge hclk);
            sleep_request <= 1'b1;
            @(posedge hclk);
            sleep_request <= 1'b0;
            @(negedge hclk);
            check(idle_enter, i[0]);
            check(sleep_enter, !i[0]);
        end
    endtask
    task automatic t_modes();
        logic [31:0] d;
        for (int m = 0; m < 8; m++) begin
            wr(A_CFG, {29'h0, m[2:0]});
            @(posedge hclk);
            @(negedge hclk);
            check(pll_enable, m[0]);
            check(usb_full_speed_ok, m[0]);
            check(pll_ref_internal, m == 1);
            rd(A_CTL, d);
            check(d[3], m > 1);
        end
        wr(A_CFG, 8'h04);
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_startup();
        t_switch();
        t_secondary();
        t_sleep();
        t_modes();
        complete_run();
    end
endmodule

bind sccs_clock_select sccs_monitor u_sccs_monitor (.*);
